// *** core/drive_state_machine.sv ***
// operating-state sequencer of the servo power stage
`timescale 1ns/1ps
`include "drive_state_regs.svh"

module drive_state_machine (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     enable_pin,
    input  wire logic                     fault_reset_pin,
    input  wire logic                     safety_power_removal_a,
    input  wire logic                     safety_power_removal_b,
    input  wire logic                     fieldbus_mode,
    input  wire logic                     canopen_bus,
    input  wire logic                     legacy_profile_compat,
    input  wire drive_state_pkg::fb_cmd_s fb_cmd,
    input  wire drive_state_pkg::error_s  error_in,
    input  wire logic                     init_done,
    input  wire logic                     first_setup_done,
    input  wire logic                     encoder_ok,
    input  wire logic                     dc_bus_ok,
    input  wire logic [15:0]              speed_rpm,
    output logic [3:0]                    state_code_q,
    output logic                          amp_on_q,
    output logic                          brake_release_q,
    output logic                          halt_req_q,
    output logic                          quick_stop_req_q,
    output logic                          encoder_check_q,
    output logic                          phase_check_q,
    output logic                          fault_clear_q
);

    drive_state_pkg::op_state_e state_q;
    drive_state_pkg::op_state_e state_d;
    logic [`SYNC_W-1:0]         pin_lvl;
    logic [`SYNC_W-1:0]         pin_rise;
    logic [`SYNC_W-1:0]         pin_fall;
    logic                       local_mode;
    logic                       en_rise;
    logic                       en_fall;
    logic                       en_high;
    logic                       clr_rise;
    logic                       safety_on;
    logic                       safety_off;
    logic                       speed_low;
    logic                       need_shutdown;
    logic                       hi_err;
    logic                       cls1_err;
    logic                       fr_start;
    logic                       fr_stop_run;
    logic                       fr_done;
    logic [2:0]                 fr_cls;
    logic                       fb_qs_q;
    logic                       c_shutdown;
    logic                       c_switch_on;
    logic                       c_enable_op;
    logic                       c_disable_op;
    logic                       c_disable_v;
    logic                       c_quick_stop;
    logic                       c_fault_reset;

    // displayed number of a state
    function automatic logic [3:0] code_of(input drive_state_pkg::op_state_e s);
        unique case (s)
            drive_state_pkg::ST_START:       code_of = `CODE_START;
            drive_state_pkg::ST_NOT_READY:   code_of = `CODE_NOT_READY;
            drive_state_pkg::ST_SW_DISABLED: code_of = `CODE_SW_DISABLED;
            drive_state_pkg::ST_READY:       code_of = `CODE_READY;
            drive_state_pkg::ST_SWITCHED_ON: code_of = `CODE_SWITCHED_ON;
            drive_state_pkg::ST_OP_ENABLED:  code_of = `CODE_OP_ENABLED;
            drive_state_pkg::ST_QUICK_STOP:  code_of = `CODE_QUICK_STOP;
            drive_state_pkg::ST_FAULT_REACT: code_of = `CODE_FAULT_REACT;
            drive_state_pkg::ST_FAULT:       code_of = `CODE_FAULT;
            default:                         code_of = `CODE_START;
        endcase
    endfunction

    // fieldbus command decode, gated by control mode
    function automatic logic is_cmd(input drive_state_pkg::fb_cmd_s c, input drive_state_pkg::fb_cmd_e k,
                                    input logic fb_mode);
        is_cmd = fb_mode && c.valid && (c.cmd == k);
    endfunction

    // local pins enter through synchronisers
    pin_sync_edge u_pins (
        .mclk    (mclk),
        .rst     (rst),
        .pin_raw ({safety_power_removal_b, safety_power_removal_a, fault_reset_pin, enable_pin}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // enable and fault-reset pin events count only in local control mode, safety pins count in both modes
    assign local_mode = ~fieldbus_mode;
    assign en_rise    = local_mode & pin_rise[`PIN_ENABLE];
    assign en_fall    = local_mode & pin_fall[`PIN_ENABLE];
    assign en_high    = local_mode & pin_lvl[`PIN_ENABLE];
    assign clr_rise   = local_mode & pin_rise[`PIN_FAULT_RESET];
    assign safety_on  = pin_lvl[`PIN_SAFETY_A] & pin_lvl[`PIN_SAFETY_B];
    assign safety_off = ~pin_lvl[`PIN_SAFETY_A] & ~pin_lvl[`PIN_SAFETY_B];
    assign speed_low  = speed_rpm < `SPEED_LIMIT_RPM;

    // commands honoured only in fieldbus control mode
    assign c_shutdown    = is_cmd(fb_cmd, drive_state_pkg::CMD_SHUTDOWN, fieldbus_mode);
    assign c_switch_on   = is_cmd(fb_cmd, drive_state_pkg::CMD_SWITCH_ON, fieldbus_mode);
    assign c_enable_op   = is_cmd(fb_cmd, drive_state_pkg::CMD_ENABLE_OP, fieldbus_mode);
    assign c_disable_op  = is_cmd(fb_cmd, drive_state_pkg::CMD_DISABLE_OP, fieldbus_mode);
    assign c_disable_v   = is_cmd(fb_cmd, drive_state_pkg::CMD_DISABLE_VOLTAGE, fieldbus_mode);
    assign c_quick_stop  = is_cmd(fb_cmd, drive_state_pkg::CMD_QUICK_STOP, fieldbus_mode);
    assign c_fault_reset = is_cmd(fb_cmd, drive_state_pkg::CMD_FAULT_RESET, fieldbus_mode);

    // shutdown gate for leaving switch-on disabled
    assign need_shutdown = fieldbus_mode & canopen_bus & legacy_profile_compat;

    // error classification
    assign hi_err   = error_in.valid && (error_in.cls >= `CLASS_QS_OFF) && (error_in.cls <= `CLASS_UNCONTROL);
    assign cls1_err = error_in.valid && (error_in.cls == `CLASS_QUICK_STOP);

    // fault reaction starts on every class 2-4 error outside fault reaction
    assign fr_start = hi_err && (state_q != drive_state_pkg::ST_FAULT_REACT);

    fault_reaction u_react (
        .mclk       (mclk),
        .rst        (rst),
        .start      (fr_start),
        .start_cls  (error_in.cls),
        .standstill (speed_rpm == `SPEED_STANDSTILL),
        .clear      (fault_clear_q),
        .stop_run_q (fr_stop_run),
        .done_q     (fr_done),
        .cls_q      (fr_cls)
    );

    // next-state selection, class 2-4 errors first
    always_comb begin
        state_d = state_q;
        if (hi_err) begin
            state_d = drive_state_pkg::ST_FAULT_REACT;
        end else begin
            unique case (state_q)
                drive_state_pkg::ST_START: begin
                    if (init_done && speed_low) state_d = drive_state_pkg::ST_NOT_READY;
                end
                drive_state_pkg::ST_NOT_READY: begin
                    if (first_setup_done) state_d = drive_state_pkg::ST_SW_DISABLED;
                end
                drive_state_pkg::ST_SW_DISABLED: begin
                    if (encoder_ok && dc_bus_ok && safety_on && speed_low &&
                        (!need_shutdown || c_shutdown)) begin
                        state_d = drive_state_pkg::ST_READY;
                    end
                end
                drive_state_pkg::ST_READY: begin
                    if (!dc_bus_ok || !speed_low || safety_off || c_disable_v) begin
                        state_d = drive_state_pkg::ST_SW_DISABLED;
                    end else if (en_rise || c_switch_on) begin
                        state_d = drive_state_pkg::ST_SWITCHED_ON;
                    end
                end
                drive_state_pkg::ST_SWITCHED_ON: begin
                    if (en_fall || c_disable_v) begin
                        state_d = drive_state_pkg::ST_SW_DISABLED;
                    end else if (c_shutdown) begin
                        state_d = drive_state_pkg::ST_READY;
                    end else if (en_high || c_enable_op) begin
                        state_d = drive_state_pkg::ST_OP_ENABLED;
                    end
                end
                drive_state_pkg::ST_OP_ENABLED: begin
                    if (en_fall || c_disable_v) begin
                        state_d = drive_state_pkg::ST_SW_DISABLED;
                    end else if (c_shutdown) begin
                        state_d = drive_state_pkg::ST_READY;
                    end else if (c_disable_op) begin
                        state_d = drive_state_pkg::ST_SWITCHED_ON;
                    end else if (cls1_err || c_quick_stop) begin
                        state_d = drive_state_pkg::ST_QUICK_STOP;
                    end
                end
                drive_state_pkg::ST_QUICK_STOP: begin
                    if (en_fall || c_disable_v) begin
                        state_d = drive_state_pkg::ST_SW_DISABLED;
                    end else if (clr_rise || c_fault_reset || (c_enable_op && fb_qs_q)) begin
                        state_d = drive_state_pkg::ST_OP_ENABLED;
                    end
                end
                drive_state_pkg::ST_FAULT_REACT: begin
                    if (fr_done) state_d = drive_state_pkg::ST_FAULT;
                end
                drive_state_pkg::ST_FAULT: begin
                    // class 4 clears only by power cycling
                    if ((clr_rise || c_fault_reset) && fr_cls != `CLASS_UNCONTROL) begin
                        state_d = drive_state_pkg::ST_SW_DISABLED;
                    end
                end
                default: state_d = drive_state_pkg::ST_START;
            endcase
        end
    end

    // state register, one transition per cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= drive_state_pkg::ST_START;
        end else begin
            state_q <= state_d;
        end
    end

    // remembers whether quick stop came from the fieldbus
    always_ff @(posedge mclk) begin
        if (rst) begin
            fb_qs_q <= 1'b0;
        end else if (state_q == drive_state_pkg::ST_OP_ENABLED && state_d == drive_state_pkg::ST_QUICK_STOP) begin
            fb_qs_q <= c_quick_stop && !cls1_err;
        end
    end

    // level responses follow the next state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_code_q     <= `CODE_START;
            amp_on_q         <= 1'b0;
            brake_release_q  <= 1'b0;
            quick_stop_req_q <= 1'b0;
        end else begin
            state_code_q     <= code_of(state_d);
            // a class 2 stop keeps the amplifier on from its first cycle, before the reaction flop has set
            amp_on_q         <= (state_d == drive_state_pkg::ST_OP_ENABLED) ||
                                (state_d == drive_state_pkg::ST_QUICK_STOP) ||
                                (state_d == drive_state_pkg::ST_FAULT_REACT &&
                                 (fr_stop_run || (fr_start && error_in.cls == `CLASS_QS_OFF)));
            brake_release_q  <= (state_d == drive_state_pkg::ST_OP_ENABLED) ||
                                (state_d == drive_state_pkg::ST_QUICK_STOP);
            quick_stop_req_q <= (state_d == drive_state_pkg::ST_QUICK_STOP) ||
                                (state_d == drive_state_pkg::ST_FAULT_REACT &&
                                 (fr_stop_run || (fr_start && error_in.cls == `CLASS_QS_OFF)));
        end
    end

    // one-cycle responses on transitions
    always_ff @(posedge mclk) begin
        if (rst) begin
            encoder_check_q <= 1'b0;
            phase_check_q   <= 1'b0;
            halt_req_q      <= 1'b0;
            fault_clear_q   <= 1'b0;
        end else begin
            encoder_check_q <= state_q == drive_state_pkg::ST_START && state_d == drive_state_pkg::ST_NOT_READY;
            phase_check_q   <= state_q == drive_state_pkg::ST_SWITCHED_ON &&
                               state_d == drive_state_pkg::ST_OP_ENABLED;
            halt_req_q      <= state_q == drive_state_pkg::ST_OP_ENABLED &&
                               state_d == drive_state_pkg::ST_SWITCHED_ON;
            fault_clear_q   <= state_q == drive_state_pkg::ST_FAULT &&
                               state_d == drive_state_pkg::ST_SW_DISABLED;
        end
    end

    a_code_matches: assert property (@(posedge mclk) disable iff (rst)
        state_code_q == code_of(state_q)) else $error("state code differs from state");

    a_reset_start: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> state_q == drive_state_pkg::ST_START && !amp_on_q) else $error("not in start after reset");

    a_error_first: assert property (@(posedge mclk) disable iff (rst)
        hi_err |=> state_q == drive_state_pkg::ST_FAULT_REACT) else $error("class 2-4 error not taken first");

    a_encoder_check: assert property (@(posedge mclk) disable iff (rst)
        ($past(state_q) == drive_state_pkg::ST_START && state_q == drive_state_pkg::ST_NOT_READY)
        |-> encoder_check_q) else $error("encoder check missing");

    a_local_ignores_cmd: assert property (@(posedge mclk) disable iff (rst)
        (state_q == drive_state_pkg::ST_READY && local_mode && !en_rise)
        |=> state_q != drive_state_pkg::ST_SWITCHED_ON) else $error("switched on without local edge");

    a_shutdown_gate: assert property (@(posedge mclk) disable iff (rst)
        (state_q == drive_state_pkg::ST_SW_DISABLED && need_shutdown && !c_shutdown)
        |=> state_q != drive_state_pkg::ST_READY) else $error("left disabled without shutdown");

    a_amp_off_fast: assert property (@(posedge mclk) disable iff (rst)
        (state_q inside {drive_state_pkg::ST_OP_ENABLED, drive_state_pkg::ST_QUICK_STOP} && !hi_err &&
         (en_fall || c_disable_v)) |=> !amp_on_q && state_q == drive_state_pkg::ST_SW_DISABLED)
        else $error("amplifier not dropped on disable");

    a_quick_stop_in: assert property (@(posedge mclk) disable iff (rst)
        (state_q == drive_state_pkg::ST_OP_ENABLED && !hi_err && !en_fall && !c_disable_v && !c_shutdown &&
         !c_disable_op && cls1_err) |=> state_q == drive_state_pkg::ST_QUICK_STOP ##0 amp_on_q && quick_stop_req_q)
        else $error("class 1 error did not quick stop");

    a_qs_resume_src: assert property (@(posedge mclk) disable iff (rst)
        ($past(state_q) == drive_state_pkg::ST_QUICK_STOP && state_q == drive_state_pkg::ST_OP_ENABLED)
        |-> ($past(clr_rise) || $past(c_fault_reset) || $past(fb_qs_q))) else $error("bad quick stop exit");

    a_fault_done: assert property (@(posedge mclk) disable iff (rst)
        (state_q == drive_state_pkg::ST_FAULT_REACT && fr_done && !hi_err) |=> state_q == drive_state_pkg::ST_FAULT)
        else $error("fault reaction did not complete");

    a_fault_clear: assert property (@(posedge mclk) disable iff (rst)
        ($past(state_q) == drive_state_pkg::ST_FAULT && state_q == drive_state_pkg::ST_SW_DISABLED)
        |-> fault_clear_q ##1 !fault_clear_q) else $error("fault clear pulse wrong");

endmodule // drive_state_machine

// *** core/drive_state_regs.svh ***
// numeric constants of the drive operating-state sequencer
`ifndef DRIVE_STATE_REGS_SVH
`define DRIVE_STATE_REGS_SVH

// displayed state numbers
`define CODE_START        4'h1
`define CODE_NOT_READY    4'h2
`define CODE_SW_DISABLED  4'h3
`define CODE_READY        4'h4
`define CODE_SWITCHED_ON  4'h5
`define CODE_OP_ENABLED   4'h6
`define CODE_QUICK_STOP   4'h7
`define CODE_FAULT_REACT  4'h8
`define CODE_FAULT        4'h9

// speed monitoring, in 1/min
`define SPEED_LIMIT_RPM   16'h03e8
`define SPEED_STANDSTILL  16'h0000

// error classes
`define CLASS_WARNING     3'h0
`define CLASS_QUICK_STOP  3'h1
`define CLASS_QS_OFF      3'h2
`define CLASS_FATAL       3'h3
`define CLASS_UNCONTROL   3'h4

// synchronised pin bits
`define SYNC_W            4
`define PIN_ENABLE        0
`define PIN_FAULT_RESET   1
`define PIN_SAFETY_A      2
`define PIN_SAFETY_B      3

`endif

// *** core/drive_state_pkg.sv ***
// types shared by the drive operating-state sequencer
package drive_state_pkg;

    typedef enum logic [2:0] {
        CMD_SHUTDOWN,
        CMD_SWITCH_ON,
        CMD_ENABLE_OP,
        CMD_DISABLE_OP,
        CMD_DISABLE_VOLTAGE,
        CMD_QUICK_STOP,
        CMD_FAULT_RESET
    } fb_cmd_e;

    typedef struct packed {
        logic    valid;
        fb_cmd_e cmd;
    } fb_cmd_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] cls;
    } error_s;

    typedef enum logic [3:0] {
        ST_START,
        ST_NOT_READY,
        ST_SW_DISABLED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OP_ENABLED,
        ST_QUICK_STOP,
        ST_FAULT_REACT,
        ST_FAULT
    } op_state_e;

endpackage

// *** core/pin_sync_edge.sv ***
// two-flop synchroniser with edge detection for the local pins
`timescale 1ns/1ps
`include "drive_state_regs.svh"

module pin_sync_edge (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [`SYNC_W-1:0]   pin_raw,
    output logic      [`SYNC_W-1:0]   level,
    output logic      [`SYNC_W-1:0]   rise,
    output logic      [`SYNC_W-1:0]   fall
);

    logic [`SYNC_W-1:0] meta_q;
    logic [`SYNC_W-1:0] sync_q;
    logic [`SYNC_W-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
            // first flop feeds only the second
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= pin_raw[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
            assign level[i] = sync_q[i];
            assign rise[i]  = sync_q[i] & ~prev_q[i];
            assign fall[i]  = ~sync_q[i] & prev_q[i];
        end
    endgenerate

endmodule // pin_sync_edge

// *** core/fault_reaction.sv ***
// error response sequencing for class 2 to 4 errors
`timescale 1ns/1ps
`include "drive_state_regs.svh"

module fault_reaction (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] start_cls,
    input  wire logic       standstill,
    input  wire logic       clear,
    output logic            stop_run_q,
    output logic            done_q,
    output logic [2:0]      cls_q
);

    logic busy_q;

    // class 2 stops first, classes 3 and 4 end at once
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_q     <= 1'b0;
            stop_run_q <= 1'b0;
            done_q     <= 1'b0;
        end else if (start) begin
            busy_q     <= 1'b1;
            stop_run_q <= (start_cls == `CLASS_QS_OFF);
            done_q     <= 1'b0;
        end else if (busy_q && (!stop_run_q || standstill)) begin
            busy_q     <= 1'b0;
            stop_run_q <= 1'b0;
            done_q     <= 1'b1;
        end else begin
            done_q     <= 1'b0;
        end
    end

    // worst class seen since the last clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            cls_q <= `CLASS_WARNING;
        end else if (start && start_cls > cls_q) begin
            cls_q <= start_cls;
        end else if (clear) begin
            cls_q <= `CLASS_WARNING;
        end
    end

endmodule // fault_reaction

// *** verification/fb_master_model.sv ***
// fieldbus master model issuing one-cycle command pulses
`timescale 1ns/1ps

module fb_master_model (
    input  wire logic               mclk,
    output drive_state_pkg::fb_cmd_s fb_cmd
);
    initial fb_cmd = '0;
    // command valid for one rising edge, field scrambled once released
    task automatic send(input drive_state_pkg::fb_cmd_e c);
        fb_cmd = '{valid: 1'b1, cmd: c};
        @(posedge mclk);
        #2 fb_cmd = '{valid: 1'b0, cmd: drive_state_pkg::fb_cmd_e'(~c)};
    endtask
endmodule // fb_master_model

// *** verification/test_drive_state_machine.sv ***
// self-checking bench of the operating-state sequencer
`timescale 1ns/1ps

module test_drive_state_machine;
    logic mclk = 1'b0, rst = 1'b1, enable_pin, fault_reset_pin, safety_power_removal_a, safety_power_removal_b;
    logic fieldbus_mode, canopen_bus, legacy_profile_compat, init_done, first_setup_done, encoder_ok, dc_bus_ok;
    logic [15:0] speed_rpm;
    logic [3:0]  state_code_q;
    logic        amp_on_q, brake_release_q, halt_req_q, quick_stop_req_q, encoder_check_q, phase_check_q, fault_clear_q;
    drive_state_pkg::fb_cmd_s fb_cmd;
    drive_state_pkg::error_s  error_in;
    int bad_count = 0, comparisons = 0;
    // command table with the state each command leads to
    drive_state_pkg::fb_cmd_e seq_cmd [16] = '{drive_state_pkg::CMD_SHUTDOWN, drive_state_pkg::CMD_SWITCH_ON,
        drive_state_pkg::CMD_ENABLE_OP, drive_state_pkg::CMD_DISABLE_OP, drive_state_pkg::CMD_ENABLE_OP,
        drive_state_pkg::CMD_SHUTDOWN, drive_state_pkg::CMD_DISABLE_VOLTAGE, drive_state_pkg::CMD_SHUTDOWN,
        drive_state_pkg::CMD_SWITCH_ON, drive_state_pkg::CMD_ENABLE_OP, drive_state_pkg::CMD_QUICK_STOP,
        drive_state_pkg::CMD_ENABLE_OP, drive_state_pkg::CMD_QUICK_STOP, drive_state_pkg::CMD_FAULT_RESET,
        drive_state_pkg::CMD_QUICK_STOP, drive_state_pkg::CMD_DISABLE_VOLTAGE};
    logic [3:0] seq_st [16] = '{4'h4, 4'h5, 4'h6, 4'h5, 4'h6, 4'h4, 4'h3, 4'h4,
                                4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h6, 4'h7, 4'h3};

    always #10 mclk = ~mclk;

    fb_master_model u_fb (.mclk, .fb_cmd);

    drive_state_machine u_dut (.mclk, .rst, .enable_pin, .fault_reset_pin, .safety_power_removal_a,
        .safety_power_removal_b, .fieldbus_mode, .canopen_bus, .legacy_profile_compat, .fb_cmd, .error_in,
        .init_done, .first_setup_done, .encoder_ok, .dc_bus_ok, .speed_rpm, .state_code_q, .amp_on_q,
        .brake_release_q, .halt_req_q, .quick_stop_req_q, .encoder_check_q, .phase_check_q, .fault_clear_q);

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    // bounded wait for a state number
    task automatic wait_state(input logic [3:0] exp);
        for (int i = 0; i < 12 && state_code_q !== exp; i++) cyc(1);
        chk("state", exp, state_code_q);
        if (state_code_q !== exp) report_and_stop();
    endtask

    // main sequence
    initial begin
        {enable_pin, fault_reset_pin, init_done, first_setup_done} = 4'h0;
        {safety_power_removal_a, safety_power_removal_b, encoder_ok, dc_bus_ok} = 4'hf;
        {fieldbus_mode, canopen_bus, legacy_profile_compat} = 3'h7;
        speed_rpm = 16'h0000;
        error_in = '0;
        cyc(5);
        rst = 1'b0;
        chk("reset state", 4'h1, state_code_q);
        init_done = 1'b1;
        wait_state(4'h2);
        chk("encoder check", 4'h1, {3'h0, encoder_check_q});
        first_setup_done = 1'b1;
        wait_state(4'h3);
        cyc(4);
        chk("held without shutdown", 4'h3, state_code_q);
        $display("test power-up done");
        for (int k = 0; k < 16; k++) begin
            u_fb.send(seq_cmd[k]);
            wait_state(seq_st[k]);
            chk("amp", {3'h0, seq_st[k] == 4'h6 || seq_st[k] == 4'h7}, {3'h0, amp_on_q});
            chk("brake", {3'h0, seq_st[k] == 4'h6 || seq_st[k] == 4'h7}, {3'h0, brake_release_q});
            chk("quick stop", {3'h0, seq_st[k] == 4'h7}, {3'h0, quick_stop_req_q});
            chk("halt", {3'h0, k == 3}, {3'h0, halt_req_q});
            chk("phase", {3'h0, k == 2 || k == 4 || k == 9}, {3'h0, phase_check_q});
        end
        $display("test command table done");
        u_fb.send(drive_state_pkg::CMD_SHUTDOWN);
        wait_state(4'h4);
        error_in = '{valid: 1'b1, cls: 3'h3};
        cyc(1);
        error_in = '0;
        wait_state(4'h8);
        wait_state(4'h9);
        chk("amp in fault", 4'h0, {3'h0, amp_on_q});
        u_fb.send(drive_state_pkg::CMD_FAULT_RESET);
        wait_state(4'h3);
        chk("fault clear", 4'h1, {3'h0, fault_clear_q});
        $display("test fault done");
        u_fb.send(drive_state_pkg::CMD_SHUTDOWN);
        wait_state(4'h4);
        u_fb.send(drive_state_pkg::CMD_SWITCH_ON);
        wait_state(4'h5);
        u_fb.send(drive_state_pkg::CMD_ENABLE_OP);
        wait_state(4'h6);
        error_in = '{valid: 1'b1, cls: 3'h1};
        cyc(1);
        error_in = '0;
        wait_state(4'h7);
        chk("amp in quick stop", 4'h1, {3'h0, amp_on_q});
        u_fb.send(drive_state_pkg::CMD_ENABLE_OP);
        cyc(2);
        chk("no enable exit", 4'h7, state_code_q);
        u_fb.send(drive_state_pkg::CMD_FAULT_RESET);
        wait_state(4'h6);
        speed_rpm = 16'h0005;
        error_in = '{valid: 1'b1, cls: 3'h2};
        cyc(1);
        error_in = '0;
        wait_state(4'h8);
        chk("amp in class 2 stop", 4'h1, {3'h0, amp_on_q});
        chk("class 2 quick stop", 4'h1, {3'h0, quick_stop_req_q});
        cyc(3);
        chk("held until standstill", 4'h8, state_code_q);
        speed_rpm = 16'h0000;
        wait_state(4'h9);
        chk("amp after class 2", 4'h0, {3'h0, amp_on_q});
        u_fb.send(drive_state_pkg::CMD_FAULT_RESET);
        wait_state(4'h3);
        $display("test error classes done");
        fieldbus_mode = 1'b0;
        u_fb.send(drive_state_pkg::CMD_DISABLE_VOLTAGE);
        wait_state(4'h4);
        enable_pin = 1'b1;
        wait_state(4'h5);
        wait_state(4'h6);
        enable_pin = 1'b0;
        wait_state(4'h3);
        $display("test local mode done");
        report_and_stop();
    end
endmodule // test_drive_state_machine
